// ==== inc/pdt_pkg.sv ====
// Constants, field layout and types shared by the prescaled down-counting timer.
// Assumes an 8-bit register port with 12-bit addresses.
package pdt_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PRESC_W = 7;
    localparam int DIV_W = 3;

    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h009;

    localparam int BIT_FLAG = 7;
    localparam int BIT_MASK = 6;
    localparam int BIT_EXT = 5;
    localparam int BIT_PIN = 4;
    localparam int BIT_PCLR = 3;
    localparam int DIV_LSB = 0;

    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_MASK = 1'b1;
    localparam logic RST_EXT = 1'b1;
    localparam logic RST_PIN = 1'b1;
    localparam logic [DIV_W-1:0] RST_DIV = 3'h7;
    localparam logic [DATA_W-1:0] RST_COUNT = 8'h00;
    localparam logic [DATA_W-1:0] COUNT_ONE = 8'h01;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_ZERO = 7'h00;

    // Oscillator to internal clock ratio is four
    localparam int OSC_DIV = 4;
    localparam int PHASE_W = 2;
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(OSC_DIV - 1);
    localparam logic [PHASE_W-1:0] PHASE_ZERO = 2'h0;

    typedef enum logic [1:0] {
        PDT_SRC_INT = 2'b00,
        PDT_SRC_GATED = 2'b01,
        PDT_SRC_OFF = 2'b10,
        PDT_SRC_PIN = 2'b11
    } pdt_src_e;

    // Low bits of the prescaler that must all be one before the selected tap falls
    function automatic logic [PRESC_W-1:0] pdt_tap_mask(input logic [DIV_W-1:0] sel);
        logic [PRESC_W-1:0] m;
        m = PRESC_ZERO;
        for (int i = 0; i < PRESC_W; i++) begin
            if (i < int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : pdt_tap_mask
endpackage : pdt_pkg

// ==== inc/pdt_presc_if.sv ====
// Carrier between the timer core and its prescaler.
// Assumes both ends share ref_clk.
`timescale 1ns/10ps
interface pdt_presc_if;
    import pdt_pkg::*;
    logic tick;
    logic clear;
    logic [DIV_W-1:0] div_sel;
    logic count_tick;

    modport core (output tick, output clear, output div_sel, input count_tick);
    modport presc (input tick, input clear, input div_sel, output count_tick);
endinterface : pdt_presc_if

// ==== rtl/pdt_prescaler.sv ====
// Seven-bit prescaler with a selectable output tap.
// Assumes tick is a one-cycle pulse per falling edge of the selected input.
`timescale 1ns/10ps
module pdt_prescaler
    import pdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    pdt_presc_if.presc pif
);
    logic [PRESC_W-1:0] presc_reg;
    logic [PRESC_W-1:0] presc_next;
    logic [PRESC_W-1:0] tap_mask;

    always_comb begin
        tap_mask = pdt_tap_mask(pif.div_sel);
        presc_next = presc_reg;
        if (pif.clear) begin
            presc_next = PRESC_ZERO; // R17
        end else if (pif.tick) begin
            presc_next = presc_reg + 7'h01; // R11
        end
    end

    // Tap bit falls on the tick that finds every lower bit set
    assign pif.count_tick = pif.tick && !pif.clear && ((presc_reg & tap_mask) == tap_mask); // R9

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= PRESC_ZERO;
        end else begin
            presc_reg <= presc_next;
        end
    end
endmodule : pdt_prescaler

// ==== rtl/pdt_timer.sv ====
// Prescaled 8-bit down-counting timer with its control register.
// Assumes ref_clk is the oscillator and all inputs but timer_pin and nrst are synchronous to it.
//
// Contract
// (R1) Both source bits set: count timer pin only
// (R2) Source code: internal, gated, off, pin
// (R3) Flag bit 7 set at zero, software-writable
// (R4) Flag cleared by any reset
// (R5) Mask bit 6 set on reset, blocks interrupt
// (R6) Source bit 5 set on reset
// (R7) Pin enable bit 4 set on reset
// (R8) Prescaler clear bit reads as zero
// (R9) Divide select picks prescaler tap 1..128
// (R10) Divide select resets to divide-by-128
// (R11) Advance on falling edge of input
// (R12) Write loads counter, otherwise counts down
// (R13) Internal clock is oscillator divided four
// (R14) External reset held over one cycle
// (R15) Low-voltage trip resets the block
// (R16) Counter wraps past zero, keeps counting
// (R17) Prescaler clear write zeroes prescaler
// (R18) Interrupt needs flag, no mask, cpu unmasked
// (R19) Counter read stable and non-disturbing
// (R20) Gated mode uses synchronised pin
// (R21) Disabled input holds counter and prescaler
`timescale 1ns/10ps
module pdt_timer
    import pdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic lvd_trip,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata,
    input wire logic timer_pin,
    input wire logic cpu_irq_mask,
    output logic timer_irq,
    output logic int_clk_out
);
    // Reset release
    logic rst_s1_reg;
    logic rst_n_sync;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_sync <= rst_s1_reg;
        end
    end

    // Control state
    logic flag_reg;
    logic flag_next;
    logic mask_reg;
    logic mask_next;
    pdt_src_e src_reg;
    pdt_src_e src_next;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic [DATA_W-1:0] count_reg;
    logic [DATA_W-1:0] count_next;
    logic [DATA_W-1:0] rdata_next;
    logic irq_next;

    // Internal clock phase and pin sampling
    logic [PHASE_W-1:0] phase_reg;
    logic [PHASE_W-1:0] phase_next;
    logic int_clk_next;
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic pin_s3_reg;

    logic int_tick;
    logic pin_fall;
    logic sel_tick;
    logic wr_ctrl;
    logic wr_count;
    logic rd_ctrl;
    logic rd_count;
    logic zero_event;

    pdt_presc_if pif ();

    pdt_prescaler u_presc (
        .clk(ref_clk),
        .rst_n(rst_n_sync),
        .pif(pif.presc)
    );

    // Address decode
    always_comb begin
        wr_ctrl = 1'b0;
        wr_count = 1'b0;
        rd_ctrl = 1'b0;
        rd_count = 1'b0;
        if (bus_addr == OFS_CTRL) begin
            wr_ctrl = bus_wr;
            rd_ctrl = bus_rd;
        end else if (bus_addr == OFS_COUNT) begin
            wr_count = bus_wr;
            rd_count = bus_rd;
        end
    end

    // Falling edge of the internal clock is the last oscillator phase
    assign int_tick = (phase_reg == PHASE_LAST); // R13
    // Only the second and third stages feed the edge detector
    assign pin_fall = pin_s3_reg && !pin_s2_reg;

    always_comb begin
        phase_next = phase_reg + 2'h1; // R13
        int_clk_next = phase_next[PHASE_W-1];
        if (lvd_trip) begin
            phase_next = PHASE_ZERO; // R15
            int_clk_next = 1'b0;
        end
    end

    // Source selection
    always_comb begin
        case (src_reg)
            PDT_SRC_INT: sel_tick = int_tick; // R2
            PDT_SRC_GATED: sel_tick = int_tick && pin_s2_reg; // R20
            PDT_SRC_OFF: sel_tick = 1'b0; // R21
            PDT_SRC_PIN: sel_tick = pin_fall; // R1
            default: sel_tick = 1'b0;
        endcase
    end

    assign pif.tick = sel_tick && !lvd_trip; // R11
    assign pif.clear = (wr_ctrl && bus_wdata[BIT_PCLR]) || lvd_trip; // R17
    assign pif.div_sel = div_reg; // R9

    // A counter write takes the cycle; a concurrent count step is dropped
    assign zero_event = pif.count_tick && !wr_count && (count_reg == COUNT_ONE); // R3

    always_comb begin
        flag_next = flag_reg;
        mask_next = mask_reg;
        src_next = src_reg;
        div_next = div_reg;
        count_next = count_reg;
        if (wr_ctrl) begin
            flag_next = bus_wdata[BIT_FLAG]; // R3
            mask_next = bus_wdata[BIT_MASK]; // R5
            src_next = pdt_src_e'({bus_wdata[BIT_EXT], bus_wdata[BIT_PIN]}); // R2
            div_next = bus_wdata[DIV_LSB +: DIV_W]; // R9
        end
        // Hardware set wins over a software clear in the same cycle
        if (zero_event) begin
            flag_next = 1'b1; // R3
        end
        if (wr_count) begin
            count_next = bus_wdata; // R12
        end else if (pif.count_tick) begin
            count_next = count_reg - COUNT_ONE; // R16
        end
        if (lvd_trip) begin
            flag_next = RST_FLAG; // R15
            mask_next = RST_MASK;
            src_next = pdt_src_e'({RST_EXT, RST_PIN});
            div_next = RST_DIV;
            count_next = RST_COUNT;
        end
    end

    // Read data registered on the strobe, so it cannot shift mid-read
    always_comb begin
        rdata_next = READ_ZERO;
        if (rd_ctrl) begin
            rdata_next[BIT_FLAG] = flag_reg;
            rdata_next[BIT_MASK] = mask_reg;
            rdata_next[BIT_EXT] = src_reg[1];
            rdata_next[BIT_PIN] = src_reg[0];
            rdata_next[BIT_PCLR] = 1'b0; // R8
            rdata_next[DIV_LSB +: DIV_W] = div_reg;
        end else if (rd_count) begin
            rdata_next = count_reg; // R19
        end
    end

    assign irq_next = flag_next && !mask_next && !cpu_irq_mask; // R18

    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            flag_reg <= RST_FLAG; // R4
            mask_reg <= RST_MASK; // R5
            src_reg <= pdt_src_e'({RST_EXT, RST_PIN}); // R6 R7
            div_reg <= RST_DIV; // R10
            count_reg <= RST_COUNT;
            bus_rdata <= READ_ZERO;
            timer_irq <= 1'b0;
            phase_reg <= PHASE_ZERO;
            int_clk_out <= 1'b0;
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            mask_reg <= mask_next;
            src_reg <= src_next;
            div_reg <= div_next;
            count_reg <= count_next;
            bus_rdata <= rdata_next;
            timer_irq <= irq_next;
            phase_reg <= phase_next;
            int_clk_out <= int_clk_next;
            pin_s1_reg <= timer_pin;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end
endmodule : pdt_timer

// ==== tb/pdt_timer_chk.sv ====
// Port-level assertions for the prescaled down-counting timer.
// Bound to pdt_timer; one ref_clk domain, reset through nrst or lvd_trip.
`timescale 1ns/10ps
module pdt_timer_chk
    import pdt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic lvd_trip,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic timer_pin,
    input wire logic cpu_irq_mask,
    input wire logic timer_irq,
    input wire logic int_clk_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst || lvd_trip);
    property p_rd_idle; !bus_rd |=> bus_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_clr_rd; bus_rd && bus_addr == OFS_CTRL |=> !bus_rdata[BIT_PCLR]; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear bit read back");
    property p_cpu_mask; cpu_irq_mask |=> !timer_irq; endproperty
    a_cpu_mask: assert property (p_cpu_mask) else $error("irq despite cpu mask");
    property p_mask_rd; bus_rd && bus_addr == OFS_CTRL ##1 bus_rdata[BIT_MASK] |-> !timer_irq; endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("irq with mask bit read set");
    property p_clk_div; $rose(int_clk_out) |=> int_clk_out ##1 !int_clk_out ##1 !int_clk_out ##1 int_clk_out;
    endproperty
    a_clk_div: assert property (p_clk_div) else $error("internal clock not divide by four");
    property p_wr_mask; bus_wr && bus_addr == OFS_CTRL && bus_wdata[BIT_MASK] |=> !timer_irq; endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("irq after mask write");
    property p_wr_flag;
        bus_wr && bus_addr == OFS_CTRL && bus_wdata[BIT_FLAG] && !bus_wdata[BIT_MASK] && !cpu_irq_mask |=> timer_irq;
    endproperty
    a_wr_flag: assert property (p_wr_flag) else $error("no irq after flag set");
    property p_irq_hold; timer_irq && !cpu_irq_mask && !bus_wr |=> timer_irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("flag dropped without write");
    c_irq: cover property ($rose(timer_irq));
    c_unmapped: cover property (bus_rd && bus_addr > OFS_CTRL);
    c_pin_fall: cover property ($fell(timer_pin));
endmodule : pdt_timer_chk

// ==== tb/pdt_cpu_model.sv ====
// Processor-side master for the timer's register port.
// Assumes strobes are sampled at ref_clk rising edges, read data one cycle later.
`timescale 1ns/10ps
module pdt_cpu_model
    import pdt_pkg::*;
(
    input wire logic ref_clk,
    output logic [ADDR_W-1:0] bus_addr,
    output logic [DATA_W-1:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [DATA_W-1:0] bus_rdata
);
    initial begin
        bus_addr = 12'h000;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        // Data stands only in the cycle after the strobe
        #1 d = bus_rdata;
    endtask : rd
endmodule : pdt_cpu_model

// ==== tb/tb_prescaled_down_counter_timer.sv ====
// Self-checking bench for the prescaled down-counting timer.
// Register traffic goes through the processor model; one ref_clk.
`timescale 1ns/10ps
module tb_prescaled_down_counter_timer;
    import pdt_pkg::*;
    logic ref_clk;
    logic nrst;
    logic lvd_trip;
    logic bus_wr;
    logic bus_rd;
    logic timer_pin;
    logic cpu_irq_mask;
    logic timer_irq;
    logic int_clk_out;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata;
    logic [DATA_W-1:0] bus_rdata;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] v0;
    int n_errors = 0;
    int checks_done = 0;
    pdt_timer dut_u (.ref_clk(ref_clk), .nrst(nrst), .lvd_trip(lvd_trip), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_pin(timer_pin),
        .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq), .int_clk_out(int_clk_out));
    pdt_cpu_model cpu_u (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata));
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        $display("mismatches %0d of %0d checks", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        cpu_u.rd(a, v);
        check(v, e);
    endtask : rdchk
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        cyc(100000);
        n_errors++;
        results();
    end
    initial begin
        nrst = 1'b0;
        lvd_trip = 1'b0;
        timer_pin = 1'b0;
        cpu_irq_mask = 1'b1;
        cyc(2);
        nrst <= 1'b1;
        cyc(3);
        rdchk(OFS_CTRL, 8'h77);
        rdchk(OFS_COUNT, RST_COUNT);
        cpu_u.wr(12'h00a, 8'hff);
        rdchk(12'h00a, 8'h00);
        // Reads spaced by two full steps, so tick phase drops out
        for (int d = 0; d < 8; d++) begin
            cpu_u.wr(OFS_CTRL, 8'h08 | 8'(d));
            cpu_u.wr(OFS_COUNT, 8'h01);
            cpu_u.rd(OFS_COUNT, v0);
            cyc((8 << d) - 2);
            rdchk(OFS_COUNT, v0 - 8'h02);
        end
        @(posedge ref_clk) cpu_irq_mask <= 1'b0;
        rdchk(OFS_CTRL, 8'h87);
        check({7'h00, timer_irq}, 8'h01);
        cpu_u.wr(OFS_CTRL, 8'hc7);
        rdchk(OFS_CTRL, 8'hc7);
        cpu_u.wr(OFS_CTRL, 8'h07);
        rdchk(OFS_CTRL, 8'h07);
        // Let the prescaler drift, then clear it: first step must wait a full 128 ticks
        cyc(200);
        cpu_u.wr(OFS_CTRL, 8'h0f);
        cpu_u.wr(OFS_COUNT, 8'h10);
        cyc(500);
        rdchk(OFS_COUNT, 8'h10);
        cyc(10);
        rdchk(OFS_COUNT, 8'h0f);
        cpu_u.wr(OFS_CTRL, 8'h80);
        rdchk(OFS_CTRL, 8'h80);
        check({7'h00, timer_irq}, 8'h01);
        cpu_u.wr(OFS_CTRL, 8'h20);
        cpu_u.wr(OFS_COUNT, 8'h5a);
        cyc(20);
        rdchk(OFS_COUNT, 8'h5a);
        rdchk(OFS_COUNT, 8'h5a);
        cpu_u.wr(OFS_CTRL, 8'h30);
        timer_pin <= 1'b1;
        cyc(4);
        cpu_u.wr(OFS_COUNT, 8'h10);
        for (int i = 0; i < 5; i++) begin
            timer_pin <= 1'b0;
            cyc(3);
            timer_pin <= (i < 4);
            cyc(3);
        end
        cyc(6);
        rdchk(OFS_COUNT, 8'h0b);
        cpu_u.wr(OFS_CTRL, 8'h90);
        cpu_u.wr(OFS_COUNT, 8'h40);
        cyc(40);
        rdchk(OFS_COUNT, 8'h40);
        @(posedge ref_clk) timer_pin <= 1'b1;
        cyc(32);
        timer_pin <= 1'b0;
        cyc(8);
        rdchk(OFS_COUNT, 8'h38);
        @(posedge ref_clk) lvd_trip <= 1'b1;
        cyc(2);
        lvd_trip <= 1'b0;
        cyc(1);
        rdchk(OFS_CTRL, 8'h77);
        rdchk(OFS_COUNT, RST_COUNT);
        // Mid-run external reset, held longer than one machine cycle
        cpu_u.wr(OFS_CTRL, 8'h80);
        cpu_u.wr(OFS_COUNT, 8'h22);
        @(posedge ref_clk) nrst <= 1'b0;
        cyc(5);
        nrst <= 1'b1;
        cyc(3);
        rdchk(OFS_CTRL, 8'h77);
        rdchk(OFS_COUNT, RST_COUNT);
        check({7'h00, timer_irq}, 8'h00);
        results();
    end
endmodule : tb_prescaled_down_counter_timer
bind pdt_timer pdt_timer_chk chk_u (.ref_clk(ref_clk), .nrst(nrst), .lvd_trip(lvd_trip), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_pin(timer_pin),
    .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq), .int_clk_out(int_clk_out));
